// ---- hw/sso_top.sv ----
// Safe-stop-1 sequencer with AHB-Lite register slave
`timescale 1ns/100ps
// Operation
// - A command going off starts deceleration and the elapsed-time count.
// - Once elapsed time reaches the monitor time while active, torque is shut off.
// - The command turning on again returns the block to normal operation.
// - A stop-triggering alarm starts the same timed stop sequence.
// - An internal diagnosis error is handled as a timed stop as well.
// - No forced deceleration: auto brake on a small amplifier gives ebrake, else dynamic brake.
// - With forced deceleration outside torque mode, command and decel alarms use forced deceleration.
// - With forced deceleration, torque mode or ebrake alarms use ebrake or dynamic brake.
// - An alarm start picks the method from that alarm's stop class.
// - Dynamic brake on an amplifier without one means the motor coasts.
// - In torque shutoff, power is cut and the dynamic brake engaged until release.
// - Forced deceleration cuts power after zero speed plus the brake sequence delay.
module sso_top #(
    parameter int TICK_CYCLES = sso_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    // AHB-Lite slave
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    // Safety inputs
    input wire logic SAFE_STOP_ONE_CMD_IN,
    input wire logic ALARM_DECEL_CLASS_IN,
    input wire logic ALARM_EBRAKE_CLASS_IN,
    input wire logic ZERO_SPEED_IN,
    input wire logic DIAG_ERROR_IN,
    // Drive controls
    output logic TIMED_STOP_OUT,
    output logic TORQUE_SHUTOFF_OUTPUT_OUT,
    output logic POWER_CUT_OUT,
    output logic DYNAMIC_BRAKE_STOP_OUT,
    output logic ELECTRONIC_BRAKE_STOP_OUT,
    output logic FORCED_DECEL_STOP_OUT
);
    localparam int EW = sso_pkg::TIME_W;

    // ==========================================================
    // Declarations
    logic [3:0] pin_meta_ff;
    logic [3:0] pin_sync_ff;
    logic cmd_on;
    logic alm_dec_in;
    logic alm_eb_in;
    logic zero_spd;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic addr_ok;
    logic [31:0] rd_word;
    logic [sso_pkg::CTRL_W-1:0] ctrl_ff;
    logic [EW-1:0] mon_time_ff;
    logic [EW-1:0] brk_delay_ff;
    logic alm_clr;
    logic alm_dec_ff;
    logic alm_eb_ff;
    logic alm_any;
    logic trig;
    logic auto_small;
    logic has_dyn;
    sso_pkg::sso_state_t state_ff;
    sso_pkg::sso_method_t method_ff;
    sso_pkg::sso_method_t nxt_method;
    sso_pkg::sso_cause_t cause_ff;
    sso_pkg::sso_cause_t nxt_cause;
    logic tick;
    logic [EW-1:0] elapsed;
    logic [EW-1:0] zs_cnt_ff;
    logic fd_cut_ff;
    logic fd_run;
    logic active_ff;
    logic tq_off_ff;
    logic power_cut_ff;
    logic dyn_ff;
    logic eb_ff;
    logic decel_ff;
    logic nxt_power_cut;
    logic nxt_dyn;
    logic nxt_eb;
    logic nxt_decel;

    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            pin_meta_ff <= 4'h0;
            pin_sync_ff <= 4'h0;
        end else begin
            pin_meta_ff <= {ZERO_SPEED_IN, ALARM_EBRAKE_CLASS_IN,
                            ALARM_DECEL_CLASS_IN, SAFE_STOP_ONE_CMD_IN};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign cmd_on = pin_sync_ff[0];
    assign alm_dec_in = pin_sync_ff[1];
    assign alm_eb_in = pin_sync_ff[2];
    assign zero_spd = pin_sync_ff[3];

    // ==========================================================
    // AHB-Lite slave, zero wait states
    assign addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    assign HRDATA_OUT = hrdata_ff;
    assign HREADYOUT_OUT = hreadyout_ff;
    assign HRESP_OUT = 1'b0;

    // Read mux, unmapped reads as zero
    always_comb begin
        rd_word = 32'h0;
        unique case (HADDR_IN[7:0])
            sso_pkg::OFS_CTRL: rd_word[sso_pkg::CTRL_W-1:0] = ctrl_ff;
            sso_pkg::OFS_MON_TIME: rd_word[EW-1:0] = mon_time_ff;
            sso_pkg::OFS_BRK_DELAY: rd_word[EW-1:0] = brk_delay_ff;
            sso_pkg::OFS_STATUS: begin
                rd_word[sso_pkg::ST_ACTIVE] = active_ff;
                rd_word[sso_pkg::ST_TORQUE_OFF] = tq_off_ff;
                rd_word[sso_pkg::ST_METHOD_LSB +: 2] = method_ff;
                rd_word[sso_pkg::ST_CAUSE_LSB +: 2] = cause_ff;
                rd_word[sso_pkg::ST_ALM_DEC] = alm_dec_ff;
                rd_word[sso_pkg::ST_ALM_EB] = alm_eb_ff;
                rd_word[sso_pkg::ST_ELAPSED_LSB +: EW] = elapsed;
            end
            default: rd_word = 32'h0;
        endcase
    end

    // Address phase capture and read data
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata_ff <= 32'h0;
            hreadyout_ff <= 1'b1;
        end else begin
            wr_pend_ff <= addr_ok && HWRITE_IN && (HSIZE_IN == sso_pkg::HSIZE_WORD);
            if (addr_ok) begin
                wr_addr_ff <= HADDR_IN[7:0];
            end
            if (addr_ok && !HWRITE_IN) begin
                hrdata_ff <= rd_word;
            end
            hreadyout_ff <= 1'b1;
        end
    end

    // Writable settings
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ctrl_ff <= sso_pkg::CTRL_RST;
            mon_time_ff <= sso_pkg::MON_TIME_RST;
            brk_delay_ff <= sso_pkg::BRK_DELAY_RST;
        end else if (wr_pend_ff) begin
            if (wr_addr_ff == sso_pkg::OFS_CTRL) begin
                ctrl_ff <= HWDATA_IN[sso_pkg::CTRL_W-1:0];
            end
            if (wr_addr_ff == sso_pkg::OFS_MON_TIME) begin
                mon_time_ff <= HWDATA_IN[EW-1:0];
            end
            if (wr_addr_ff == sso_pkg::OFS_BRK_DELAY) begin
                brk_delay_ff <= HWDATA_IN[EW-1:0];
            end
        end
    end

    assign alm_clr = wr_pend_ff && (wr_addr_ff == sso_pkg::OFS_STATUS)
                     && HWDATA_IN[sso_pkg::ST_ALM_CLR];

    // ==========================================================
    // Alarm latches, set wins over software clear
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            alm_dec_ff <= 1'b0;
            alm_eb_ff <= 1'b0;
        end else begin
            alm_dec_ff <= alm_dec_in || DIAG_ERROR_IN || (alm_dec_ff && !alm_clr);
            alm_eb_ff <= alm_eb_in || (alm_eb_ff && !alm_clr);
        end
    end

    assign alm_any = alm_dec_ff || alm_eb_ff;
    assign trig = !cmd_on || alm_any;
    assign auto_small = ctrl_ff[sso_pkg::CTRL_EB_AUTO] && ctrl_ff[sso_pkg::CTRL_SMALL_AMP];
    assign has_dyn = ctrl_ff[sso_pkg::CTRL_HAS_DYN];

    // ==========================================================
    // Cause and stop method selection
    always_comb begin
        if (alm_eb_ff) begin
            nxt_cause = sso_pkg::CAUSE_EB_ALM;
        end else if (alm_dec_ff) begin
            nxt_cause = sso_pkg::CAUSE_DEC_ALM;
        end else begin
            nxt_cause = sso_pkg::CAUSE_CMD;
        end
        if (!ctrl_ff[sso_pkg::CTRL_FD_SEL] || ctrl_ff[sso_pkg::CTRL_TORQUE]
            || nxt_cause == sso_pkg::CAUSE_EB_ALM) begin
            nxt_method = auto_small ? sso_pkg::METHOD_EBK : sso_pkg::METHOD_DYN;
        end else begin
            nxt_method = sso_pkg::METHOD_FDC;
        end
    end

    // ==========================================================
    // Sequencer
    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state_ff <= sso_pkg::ST_RUN;
            cause_ff <= sso_pkg::CAUSE_NONE;
            method_ff <= sso_pkg::METHOD_DYN;
        end else begin
            unique case (state_ff)
                sso_pkg::ST_RUN: begin
                    if (trig) begin
                        state_ff <= sso_pkg::ST_DECEL;
                        cause_ff <= nxt_cause;
                        method_ff <= nxt_method;
                    end
                end
                sso_pkg::ST_DECEL: begin
                    if (!trig) begin
                        state_ff <= sso_pkg::ST_RUN;
                    end else if (elapsed >= mon_time_ff) begin
                        state_ff <= sso_pkg::ST_SHUTOFF;
                    end
                end
                sso_pkg::ST_SHUTOFF: begin
                    if (!trig) begin
                        state_ff <= sso_pkg::ST_RUN;
                    end
                end
                default: state_ff <= sso_pkg::ST_RUN;
            endcase
        end
    end

    // Elapsed time, held at zero outside a stop
    sso_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .clk_in(CLK_IN),
        .nrst_in(NRST_IN),
        .clear_in(state_ff == sso_pkg::ST_RUN),
        .tick_out(tick),
        .elapsed_out(elapsed)
    );

    // ==========================================================
    // Zero speed plus brake delay under forced deceleration
    assign fd_run = (state_ff == sso_pkg::ST_DECEL) && (method_ff == sso_pkg::METHOD_FDC);

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            zs_cnt_ff <= '0;
            fd_cut_ff <= 1'b0;
        end else if (!fd_run) begin
            zs_cnt_ff <= '0;
            fd_cut_ff <= 1'b0;
        end else begin
            if (!zero_spd) begin
                zs_cnt_ff <= '0;
            end else if (tick && zs_cnt_ff != '1) begin
                zs_cnt_ff <= zs_cnt_ff + 1'b1;
            end
            // One tick beyond the delay: the first tick may come at once
            if (zero_spd && zs_cnt_ff > brk_delay_ff) begin
                fd_cut_ff <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Drive control outputs
    always_comb begin
        nxt_power_cut = 1'b0;
        nxt_dyn = 1'b0;
        nxt_eb = 1'b0;
        nxt_decel = 1'b0;
        unique case (state_ff)
            sso_pkg::ST_RUN: nxt_power_cut = 1'b0;
            sso_pkg::ST_DECEL: begin
                unique case (method_ff)
                    sso_pkg::METHOD_EBK: nxt_eb = 1'b1;
                    sso_pkg::METHOD_FDC: begin
                        nxt_decel = !fd_cut_ff;
                        nxt_power_cut = fd_cut_ff;
                        nxt_dyn = fd_cut_ff && has_dyn;
                    end
                    default: begin
                        nxt_power_cut = 1'b1;
                        nxt_dyn = has_dyn;
                    end
                endcase
            end
            sso_pkg::ST_SHUTOFF: begin
                nxt_power_cut = 1'b1;
                nxt_dyn = has_dyn;
            end
            default: nxt_power_cut = 1'b1;
        endcase
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            active_ff <= 1'b0;
            tq_off_ff <= 1'b0;
            power_cut_ff <= 1'b0;
            dyn_ff <= 1'b0;
            eb_ff <= 1'b0;
            decel_ff <= 1'b0;
        end else begin
            active_ff <= (state_ff != sso_pkg::ST_RUN);
            tq_off_ff <= (state_ff == sso_pkg::ST_SHUTOFF);
            power_cut_ff <= nxt_power_cut;
            dyn_ff <= nxt_dyn;
            eb_ff <= nxt_eb;
            decel_ff <= nxt_decel;
        end
    end

    assign TIMED_STOP_OUT = active_ff;
    assign TORQUE_SHUTOFF_OUTPUT_OUT = tq_off_ff;
    assign POWER_CUT_OUT = power_cut_ff;
    assign DYNAMIC_BRAKE_STOP_OUT = dyn_ff;
    assign ELECTRONIC_BRAKE_STOP_OUT = eb_ff;
    assign FORCED_DECEL_STOP_OUT = decel_ff;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    sequence s_run_trig;
        state_ff == sso_pkg::ST_RUN && trig;
    endsequence
    sequence s_stopped;
        state_ff != sso_pkg::ST_RUN;
    endsequence

    property p_cmd_start;
        state_ff == sso_pkg::ST_RUN && !cmd_on |=> state_ff == sso_pkg::ST_DECEL ##1 active_ff;
    endproperty
    a_cmd_start: assert property (p_cmd_start) else $error("stop did not start");

    property p_time_out;
        state_ff == sso_pkg::ST_DECEL && trig && elapsed >= mon_time_ff
        |=> state_ff == sso_pkg::ST_SHUTOFF ##1 tq_off_ff;
    endproperty
    a_time_out: assert property (p_time_out) else $error("shutoff missed");

    property p_return;
        s_stopped ##0 (cmd_on && !alm_any) |=> state_ff == sso_pkg::ST_RUN ##1 !active_ff;
    endproperty
    a_return: assert property (p_return) else $error("no return to run");

    property p_alarm_start;
        state_ff == sso_pkg::ST_RUN && alm_any
        |=> state_ff == sso_pkg::ST_DECEL && cause_ff != sso_pkg::CAUSE_CMD;
    endproperty
    a_alarm_start: assert property (p_alarm_start) else $error("alarm stop missed");

    property p_diag;
        DIAG_ERROR_IN |=> alm_dec_ff ##1 s_stopped;
    endproperty
    a_diag: assert property (p_diag) else $error("diagnosis stop missed");

    property p_no_fd;
        s_run_trig ##0 !ctrl_ff[sso_pkg::CTRL_FD_SEL]
        |=> method_ff == ($past(auto_small) ? sso_pkg::METHOD_EBK : sso_pkg::METHOD_DYN);
    endproperty
    a_no_fd: assert property (p_no_fd) else $error("wrong method without fd");

    property p_fd_sd;
        s_run_trig ##0 (ctrl_ff[sso_pkg::CTRL_FD_SEL] && !ctrl_ff[sso_pkg::CTRL_TORQUE]
        && !alm_eb_ff) |=> method_ff == sso_pkg::METHOD_FDC;
    endproperty
    a_fd_sd: assert property (p_fd_sd) else $error("fd not chosen");

    property p_fd_brake;
        s_run_trig ##0 (ctrl_ff[sso_pkg::CTRL_FD_SEL] && (ctrl_ff[sso_pkg::CTRL_TORQUE]
        || alm_eb_ff))
        |=> method_ff == ($past(auto_small) ? sso_pkg::METHOD_EBK : sso_pkg::METHOD_DYN);
    endproperty
    a_fd_brake: assert property (p_fd_brake) else $error("wrong brake with fd");

    property p_alarm_class;
        s_run_trig ##0 alm_eb_ff |=> cause_ff == sso_pkg::CAUSE_EB_ALM;
    endproperty
    a_alarm_class: assert property (p_alarm_class) else $error("alarm class lost");

    property p_coast;
        state_ff == sso_pkg::ST_SHUTOFF && !has_dyn |=> power_cut_ff && !dyn_ff;
    endproperty
    a_coast: assert property (p_coast) else $error("brake without unit");

    property p_shutoff;
        state_ff == sso_pkg::ST_SHUTOFF && has_dyn |=> power_cut_ff && dyn_ff && tq_off_ff;
    endproperty
    a_shutoff: assert property (p_shutoff) else $error("shutoff outputs wrong");

    property p_fd_cut;
        fd_run && fd_cut_ff |=> power_cut_ff && !decel_ff;
    endproperty
    a_fd_cut: assert property (p_fd_cut) else $error("fd cut missed");

    property p_clear;
        state_ff == sso_pkg::ST_RUN |=> elapsed == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("elapsed not cleared");
endmodule

// ---- pkg/sso_pkg.sv ----
// Package: register map, field layout, timing and types of the safe-stop-1 sequencer
package sso_pkg;
    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MON_TIME = 8'h04;
    localparam logic [7:0] OFS_BRK_DELAY = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;

    // ==========================================================
    // Control register fields
    localparam int CTRL_W = 5;
    localparam int CTRL_FD_SEL = 0;
    localparam int CTRL_EB_AUTO = 1;
    localparam int CTRL_SMALL_AMP = 2;
    localparam int CTRL_HAS_DYN = 3;
    localparam int CTRL_TORQUE = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;

    // ==========================================================
    // Status register fields
    localparam int ST_ACTIVE = 0;
    localparam int ST_TORQUE_OFF = 1;
    localparam int ST_METHOD_LSB = 2;
    localparam int ST_CAUSE_LSB = 4;
    localparam int ST_ALM_DEC = 6;
    localparam int ST_ALM_EB = 7;
    localparam int ST_ELAPSED_LSB = 16;
    localparam int ST_ALM_CLR = 0;

    // ==========================================================
    // Times and widths
    localparam int TIME_W = 16;
    localparam logic [15:0] MON_TIME_RST = 16'h0064;
    localparam logic [15:0] BRK_DELAY_RST = 16'h0000;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS * 1000 / CLK_PERIOD_PS;
    localparam int TICK_W = 18;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {ST_RUN, ST_DECEL, ST_SHUTOFF} sso_state_t;
    typedef enum logic [1:0] {METHOD_DYN, METHOD_EBK, METHOD_FDC} sso_method_t;
    typedef enum logic [1:0] {CAUSE_NONE, CAUSE_CMD, CAUSE_DEC_ALM, CAUSE_EB_ALM} sso_cause_t;
endpackage

// ---- hw/sso_timer.sv ----
// Millisecond divider and elapsed-time counter for the safe-stop sequencer
`timescale 1ns/100ps
module sso_timer #(
    parameter int TICK_CYCLES = sso_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Control
    input wire logic clear_in,
    // Results
    output logic tick_out,
    output logic [sso_pkg::TIME_W-1:0] elapsed_out
);
    localparam int TW = sso_pkg::TICK_W;
    localparam int EW = sso_pkg::TIME_W;
    localparam logic [TW-1:0] DIV_LAST = TW'(TICK_CYCLES - 1);

    logic [TW-1:0] div_ff;
    logic tick_ff;
    logic [EW-1:0] elapsed_ff;
    logic wrap;

    assign wrap = (div_ff == DIV_LAST);
    assign tick_out = tick_ff;
    assign elapsed_out = elapsed_ff;

    // ==========================================================
    // Divider, restarts on clear so the first step is whole
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_ff <= '0;
            tick_ff <= 1'b0;
        end else if (clear_in || wrap) begin
            div_ff <= '0;
            tick_ff <= wrap && !clear_in;
        end else begin
            div_ff <= div_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

    // Elapsed count, saturating
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            elapsed_ff <= '0;
        end else if (clear_in) begin
            elapsed_ff <= '0;
        end else if (wrap && elapsed_ff != '1) begin
            elapsed_ff <= elapsed_ff + 1'b1;
        end
    end
endmodule

// ---- verification/sso_drive_model.sv ----
// Far-side model: safety input device and amplifier speed feedback
`timescale 1ns/100ps
module sso_drive_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Requests from the bench
    input wire logic stop_req_in,
    input wire logic dec_alm_req_in,
    input wire logic eb_alm_req_in,
    input wire logic [7:0] decel_cycles_in,
    // Drive state seen by the amplifier
    input wire logic stopping_in,
    input wire logic decel_in,
    // Pins towards the sequencer
    output logic cmd_out,
    output logic dec_alm_out,
    output logic eb_alm_out,
    output logic zero_speed_out
);
    logic [7:0] speed_ff;

    // ==========================================================
    // Command pin high means run; pins move just after an edge
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_out <= 1'b1;
            dec_alm_out <= 1'b0;
            eb_alm_out <= 1'b0;
        end else begin
            cmd_out <= !stop_req_in;
            dec_alm_out <= dec_alm_req_in;
            eb_alm_out <= eb_alm_req_in;
        end
    end

    // Speed falls only while forced deceleration runs
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            speed_ff <= 8'hff;
        end else if (!stopping_in) begin
            speed_ff <= decel_cycles_in;
        end else if (decel_in && speed_ff != 8'h00) begin
            speed_ff <= speed_ff - 8'h01;
        end
    end

    // Zero speed reported once stopped
    assign zero_speed_out = stopping_in && (speed_ff == 8'h00);
endmodule

// ---- verification/sso_top_bench.sv ----
// Self-checking bench for the safe-stop-1 sequencer
`timescale 1ns/100ps
module sso_top_bench;
    localparam int TICK = 10;
    logic clk, nrst, hsel, hwrite, hready, hresp, stop_req, dec_req, eb_req, diag;
    logic cmd, alm_d, alm_e, zspd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [5:0] outs;
    logic [7:0] decel_cyc;
    logic [15:0] lfsr_ff;
    int num_errors = 0;
    int checks_done = 0;

    // ==========================================================
    // Design and far side
    sso_top #(.TICK_CYCLES(TICK)) i_dut (
        .CLK_IN(clk), .NRST_IN(nrst), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .SAFE_STOP_ONE_CMD_IN(cmd), .ALARM_DECEL_CLASS_IN(alm_d),
        .ALARM_EBRAKE_CLASS_IN(alm_e), .ZERO_SPEED_IN(zspd), .DIAG_ERROR_IN(diag),
        .TIMED_STOP_OUT(outs[5]), .TORQUE_SHUTOFF_OUTPUT_OUT(outs[4]),
        .POWER_CUT_OUT(outs[3]), .DYNAMIC_BRAKE_STOP_OUT(outs[2]),
        .ELECTRONIC_BRAKE_STOP_OUT(outs[1]), .FORCED_DECEL_STOP_OUT(outs[0]));
    sso_drive_model i_far (
        .clk_in(clk), .nrst_in(nrst), .stop_req_in(stop_req), .dec_alm_req_in(dec_req),
        .eb_alm_req_in(eb_req), .decel_cycles_in(decel_cyc), .stopping_in(outs[5]),
        .decel_in(outs[0]), .cmd_out(cmd), .dec_alm_out(alm_d), .eb_alm_out(alm_e),
        .zero_speed_out(zspd));

    // ==========================================================
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("mismatches %0d comparisons %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Stop method from settings and cause
    function automatic logic [1:0] exp_method(input logic [4:0] c, input logic [1:0] cause);
        if (!c[sso_pkg::CTRL_FD_SEL] || c[sso_pkg::CTRL_TORQUE] || cause == 2'h3) begin
            return (c[sso_pkg::CTRL_EB_AUTO] && c[sso_pkg::CTRL_SMALL_AMP]) ? 2'h1 : 2'h0;
        end
        return 2'h2;
    endfunction

    // Outputs {cut, dyn, ebrake, decel} while the method runs
    function automatic logic [3:0] exp_outs(input logic [1:0] m, input logic has_dyn);
        case (m)
            2'h0: return {1'b1, has_dyn, 2'b00};
            2'h1: return 4'b0010;
            default: return 4'b0001;
        endcase
    endfunction

    // One single-word AHB transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= sso_pkg::HSIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 50);
        rd = hrdata;
        check(32'(hresp), 32'h0);
        check(32'(n < 50), 32'h1);
    endtask

    task automatic wait_bit(input int b, input logic lvl, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (outs[b] !== lvl && n < 3000);
        check(32'(n < 3000), 32'h1);
    endtask

    // ==========================================================
    // One stop by command or alarm, then return to run
    task automatic run_stop(input logic [4:0] c, input logic [1:0] cause, input logic dg);
        int n;
        logic [1:0] m;
        m = exp_method(c, cause);
        bus(1'b1, sso_pkg::OFS_CTRL, {27'h0, c});
        @(posedge clk);
        stop_req <= (cause == 2'h1);
        eb_req <= (cause == 2'h3);
        dec_req <= (cause == 2'h2) && !dg;
        diag <= (cause == 2'h2) && dg;
        wait_bit(5, 1'b1, n);
        @(posedge clk);
        diag <= 1'b0;
        repeat (2) @(negedge clk);
        check(32'(outs[3:0]), 32'(exp_outs(m, c[3])));
        bus(1'b0, sso_pkg::OFS_STATUS, 32'h0);
        check(32'(rd[5:2]), 32'({cause, m}));
        @(posedge clk);
        stop_req <= 1'b0;
        eb_req <= 1'b0;
        dec_req <= 1'b0;
        if (cause != 2'h1) begin
            repeat (6) @(negedge clk);
            bus(1'b1, sso_pkg::OFS_STATUS, 32'h1);
        end
        wait_bit(5, 1'b0, n);
        bus(1'b0, sso_pkg::OFS_STATUS, 32'h0);
        check(32'({rd[31:16], rd[7:6], rd[1:0]}), 32'h0);
    endtask

    // Forced deceleration run into torque shutoff
    task automatic run_shutoff(input int mon, input logic dyn);
        int n, t_cut;
        bus(1'b1, sso_pkg::OFS_CTRL, {28'h0, dyn, 3'h1});
        bus(1'b1, sso_pkg::OFS_MON_TIME, {16'h0, 16'(mon)});
        bus(1'b1, sso_pkg::OFS_BRK_DELAY, 32'h1);
        @(posedge clk);
        stop_req <= 1'b1;
        wait_bit(5, 1'b1, n);
        n = 0;
        t_cut = 0;
        while (outs[4] !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
            if (outs[3] === 1'b1 && t_cut == 0) t_cut = n;
        end
        check(32'(n >= mon * TICK - 1 && n <= mon * TICK + 2), 32'h1);
        check(32'(outs), 32'({3'b111, dyn, 2'b00}));
        if (mon > 0) begin
            check(32'(t_cut >= decel_cyc + 9 && t_cut <= decel_cyc + 24), 32'h1);
        end
        stop_req <= 1'b0;
        wait_bit(5, 1'b0, n);
        bus(1'b0, sso_pkg::OFS_STATUS, 32'h0);
        check(32'(rd[31:16]), 32'h0);
    endtask

    // ==========================================================
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #400000;
        num_errors++;
        conclude();
    end

    // Main sequence
    initial begin
        {nrst, hsel, hwrite, stop_req, dec_req, eb_req, diag} = 7'h00;
        htrans = 2'h0;
        hsize = 3'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        decel_cyc = 8'h0f;
        lfsr_ff = 16'h5783;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        bus(1'b0, sso_pkg::OFS_CTRL, 32'h0);
        check(rd, {27'h0, sso_pkg::CTRL_RST});
        bus(1'b0, sso_pkg::OFS_MON_TIME, 32'h0);
        check(rd, {16'h0, sso_pkg::MON_TIME_RST});
        bus(1'b0, sso_pkg::OFS_BRK_DELAY, 32'h0);
        check(rd, {16'h0, sso_pkg::BRK_DELAY_RST});
        bus(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0);
        lfsr_ff = lfsr(lfsr_ff);
        bus(1'b1, sso_pkg::OFS_MON_TIME, {16'h0, lfsr_ff});
        bus(1'b0, sso_pkg::OFS_MON_TIME, 32'h0);
        check(rd, {16'h0, lfsr_ff});
        run_shutoff(5, 1'b1);
        run_shutoff(0, 1'b0);
        bus(1'b1, sso_pkg::OFS_MON_TIME, 32'h64);
        // Every setting with every cause, slow deceleration
        for (int i = 0; i < 96; i++) begin
            lfsr_ff = lfsr(lfsr_ff);
            decel_cyc <= 8'hc0 | lfsr_ff[7:0];
            run_stop(5'(i % 32), 2'(i / 32 + 1), lfsr_ff[8]);
        end
        conclude();
    end
endmodule
